// ### hdl/xbm_regs.svh
`ifndef XBM_REGS_SVH
`define XBM_REGS_SVH

// address fields
`define XBM_ADDR_HI        31
`define XBM_BASE_LO        20
`define XBM_BASE_W         12
`define XBM_WORD_HI        19
`define XBM_WORD_LO        2
`define XBM_AD_ADDR_W      18
`define XBM_AD_ZERO_W      14

// widths
`define XBM_AD_W           32
`define XBM_LANES          4

// data phase length in link clock periods
`define XBM_DATA_TICKS     3'h2
`define XBM_TICK_W         3

// reset values of pins
`define XBM_LANES_IDLE     4'hf
`define XBM_AD_RESET       32'h0000_0000

`endif

// ### hdl/xbm_pkg.sv
package xbm_pkg;

    // bus cycle sequencer states, one-hot
    typedef enum logic [4:0] {
        XBM_IDLE   = 5'h01,
        XBM_REQ    = 5'h02,
        XBM_ADDR   = 5'h04,
        XBM_DATA   = 5'h08,
        XBM_FINISH = 5'h10
    } xbm_state_t;

    // strobe style of the expansion bus
    typedef enum logic {
        XBM_LATCH_STYLE  = 1'b0,
        XBM_STROBE_STYLE = 1'b1
    } xbm_style_t;

endpackage

// ### hdl/xbm_sync.sv
`timescale 1ns/1ps
module xbm_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // two stage synchroniser per bit; stage one is read by stage two only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i] ^ reset_val[i] ^ reset_val[i];
                end
            end
        end
    endgenerate

endmodule

// ### hdl/xbm_timer.sv
`timescale 1ns/1ps
`include "xbm_regs.svh"
module xbm_timer (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    // control
    input  wire logic                   load,
    input  wire logic [`XBM_TICK_W-1:0] load_val,
    input  wire logic                   tick,
    // status
    output logic                        done
);

    logic [`XBM_TICK_W-1:0] count_reg;

    // counts link clock periods; done is high while one period or none is left
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_val;
        end else if (tick && count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign done = (count_reg <= `XBM_TICK_W'(1));

endmodule

// ### hdl/xbm_port.sv
`timescale 1ns/1ps
`include "xbm_regs.svh"
// Notes on behaviour
// (RQ1) expansion clock out is the received PCI clock inverted
// (RQ2) address phase puts PCI address bits 19:2 on bus bits 17:0
// (RQ3) address phase drives bus bits 31:18 to zero
// (RQ4) data phase passes all 32 data bits unaltered
// (RQ5) each active-low lane select is a chip select for its byte
// (RQ6) lane selects carry data-phase byte enables only, never the command
// (RQ7) lane selects stay high outside the data phase
// (RQ8) latch style: write strobe low presents data, rising edge marks write
// (RQ9) strobe style: direction high for whole read, low for whole write
// (RQ10) latch style: read strobe low for reads, high throughout writes
// (RQ11) strobe style: data strobe low for reads and writes until the end
// (RQ12) latch style: address latch low from valid address through data phase
// (RQ13) strobe style: address strobe low from address phase through data phase, high in finish
// (RQ14) local interrupt input is relayed to the PCI interrupt B output
// (RQ15) bus request is asserted whenever the port needs the bus
// (RQ16) arbiter grants the bus, or ties grant asserted when alone
// (RQ17) after grant, acknowledge is asserted and held for the cycle
// (RQ18) no bus drive before grant; bus released after acknowledge drops
// (RQ19) only accesses whose upper address matches the base are taken
module xbm_port
    import xbm_pkg::*;
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    sys_rst,
    // configuration
    input  wire logic                    strobe_style,
    input  wire logic [`XBM_BASE_W-1:0]  expansion_space,
    // pci target side request
    input  wire logic                    req_valid,
    output logic                         req_ready,
    input  wire logic [`XBM_AD_W-1:0]    req_addr,
    input  wire logic                    req_write,
    input  wire logic [`XBM_LANES-1:0]   req_be_n,
    input  wire logic [`XBM_AD_W-1:0]    req_wdata,
    // pci target side answer
    output logic                         rsp_valid,
    output logic                         rsp_miss,
    output logic [`XBM_AD_W-1:0]         rsp_rdata,
    // pci clock and interrupt
    input  wire logic                    pci_clk_in,
    output logic                         pci_intb_n,
    // expansion bus clock and address/data
    output logic                         exp_clock_out,
    input  wire logic [`XBM_AD_W-1:0]    exp_addr_data_in,
    output logic [`XBM_AD_W-1:0]         exp_addr_data_out,
    output logic                         exp_addr_data_oe,
    // expansion bus strobes and selects
    output logic [`XBM_LANES-1:0]        lane_select_n,
    output logic                         write_strobe_n,
    output logic                         data_strobe_n,
    output logic                         addr_strobe_n,
    output logic                         exp_ctrl_oe,
    // interrupt and arbitration
    input  wire logic                    local_irq_in_n,
    output logic                         request_alt_n,
    input  wire logic                    bus_grant_in,
    input  wire logic                    grant_alt_n,
    output logic                         grant_ack_n
);

    xbm_state_t state_reg;
    xbm_state_t state_next;

    logic [`XBM_AD_W-1:0]  ad_sync;
    logic [3:0]            pin_sync;
    logic                  pclk_s;
    logic                  irq_s_n;
    logic                  hold_s;
    logic                  grant_alt_s_n;
    logic                  pclk_d_reg;
    logic                  tick;
    logic                  granted;
    logic                  hit;
    logic                  take;
    logic                  phase_done;
    logic                  style_reg;

    logic [`XBM_AD_W-1:0]  addr_reg;
    logic [`XBM_AD_W-1:0]  wdata_reg;
    logic [`XBM_LANES-1:0] be_n_reg;
    logic                  write_reg;

    // pins from outside the clock domain
    xbm_sync #(.WIDTH(4)) u_pin_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in ({pci_clk_in, ~local_irq_in_n, bus_grant_in, ~grant_alt_n}),
        .reset_val(4'h0),
        .sync_out (pin_sync)
    );

    xbm_sync #(.WIDTH(`XBM_AD_W)) u_ad_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (exp_addr_data_in),
        .reset_val(`XBM_AD_RESET),
        .sync_out (ad_sync)
    );

    assign pclk_s        = pin_sync[3];
    // active-low pins pass inverted so the cleared synchroniser reads as idle
    assign irq_s_n       = ~pin_sync[2];
    assign hold_s        = pin_sync[1];
    assign grant_alt_s_n = ~pin_sync[0];

    // rising edge of the pci clock paces the bus sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pclk_d_reg <= 1'b0;
        end else begin
            pclk_d_reg <= pclk_s;
        end
    end

    assign tick = pclk_s & ~pclk_d_reg;

    // grant polarity follows the strobe style
    assign granted = (style_reg == XBM_STROBE_STYLE) ? ~grant_alt_s_n : hold_s;

    assign hit  = (req_addr[`XBM_ADDR_HI:`XBM_BASE_LO] == expansion_space); // [RQ19]
    assign take = req_valid & req_ready;

    // data phase length timer
    xbm_timer u_timer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .load    (tick && state_reg == XBM_ADDR),
        .load_val(`XBM_DATA_TICKS),
        .tick    (tick),
        .done    (phase_done)
    );

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            XBM_IDLE: begin
                if (take && hit) begin
                    state_next = XBM_REQ;
                end
            end
            XBM_REQ: begin
                if (tick && granted) begin // [RQ17] [RQ18]
                    state_next = XBM_ADDR;
                end
            end
            XBM_ADDR: begin
                if (tick) begin
                    state_next = XBM_DATA;
                end
            end
            XBM_DATA: begin
                if (tick && phase_done) begin
                    state_next = XBM_FINISH;
                end
            end
            XBM_FINISH: begin
                if (tick) begin
                    state_next = XBM_IDLE;
                end
            end
            default: begin
                state_next = XBM_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= XBM_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request capture; style is frozen per access so strobes never change meaning mid cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
            be_n_reg  <= `XBM_LANES_IDLE;
            write_reg <= 1'b0;
            style_reg <= XBM_LATCH_STYLE;
        end else if (take) begin
            addr_reg  <= req_addr;
            wdata_reg <= req_wdata;
            be_n_reg  <= req_be_n;
            write_reg <= req_write;
            style_reg <= xbm_style_t'(strobe_style);
        end
    end

    // pci side handshake and answer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_miss  <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            req_ready <= (state_next == XBM_IDLE) && !take;
            rsp_valid <= (take && !hit) || (state_reg == XBM_FINISH && state_next == XBM_IDLE);
            rsp_miss  <= take && !hit;
            if (state_reg == XBM_DATA && state_next == XBM_FINISH && !write_reg) begin
                rsp_rdata <= ad_sync; // read data sampled as the strobe ends
            end
        end
    end

    // clock relay and interrupt relay
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_clock_out <= 1'b1;
            pci_intb_n    <= 1'b1;
        end else begin
            exp_clock_out <= ~pclk_s;  // [RQ1]
            pci_intb_n    <= irq_s_n;  // [RQ14]
        end
    end

    // arbitration pins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            request_alt_n <= 1'b1;
            grant_ack_n   <= 1'b1;
        end else begin
            request_alt_n <= !(state_next inside {XBM_REQ, XBM_ADDR, XBM_DATA, XBM_FINISH}); // [RQ15]
            grant_ack_n   <= !(state_next inside {XBM_ADDR, XBM_DATA});                      // [RQ17]
        end
    end

    // bus drive; finish keeps driving one period so strobes are seen high before release
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_ctrl_oe       <= 1'b0;
            exp_addr_data_oe  <= 1'b0;
            exp_addr_data_out <= `XBM_AD_RESET;
        end else begin
            exp_ctrl_oe       <= state_next inside {XBM_ADDR, XBM_DATA, XBM_FINISH}; // [RQ18]
            exp_addr_data_oe  <= (state_next == XBM_ADDR) || (state_next == XBM_DATA && write_reg);
            if (state_next == XBM_ADDR) begin
                exp_addr_data_out <= {{`XBM_AD_ZERO_W{1'b0}},                         // [RQ3]
                                      addr_reg[`XBM_WORD_HI:`XBM_WORD_LO]};          // [RQ2]
            end else if (state_next == XBM_DATA) begin
                exp_addr_data_out <= wdata_reg;                                     // [RQ4]
            end
        end
    end

    // lane selects and strobes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lane_select_n  <= `XBM_LANES_IDLE;
            write_strobe_n <= 1'b1;
            data_strobe_n  <= 1'b1;
            addr_strobe_n  <= 1'b1;
        end else begin
            lane_select_n  <= (state_next == XBM_DATA) ? be_n_reg : `XBM_LANES_IDLE; // [RQ5] [RQ6] [RQ7]
            addr_strobe_n  <= !(state_next inside {XBM_ADDR, XBM_DATA});             // [RQ12] [RQ13]
            if (style_reg == XBM_STROBE_STYLE) begin
                // direction held over the whole access
                write_strobe_n <= (state_next inside {XBM_ADDR, XBM_DATA, XBM_FINISH}) ?
                                  !write_reg : 1'b1;                                  // [RQ9]
                data_strobe_n  <= !(state_next == XBM_DATA);                          // [RQ11]
            end else begin
                write_strobe_n <= !(state_next == XBM_DATA && write_reg);             // [RQ8]
                data_strobe_n  <= !(state_next == XBM_DATA && !write_reg);            // [RQ10]
            end
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_clock_inverse: assert property (exp_clock_out == !$past(pclk_s)) // [RQ1]
        else $error("expansion clock is not the inverted pci clock");
    a_addr_low_bits: assert property (state_reg == XBM_ADDR |->          // [RQ2]
            exp_addr_data_out[`XBM_AD_ADDR_W-1:0] == addr_reg[`XBM_WORD_HI:`XBM_WORD_LO])
        else $error("address phase carries wrong address bits");
    a_addr_upper_zero: assert property (state_reg == XBM_ADDR |->        // [RQ3]
            exp_addr_data_out[`XBM_AD_W-1:`XBM_AD_ADDR_W] == '0 && exp_addr_data_oe)
        else $error("upper bus bits not zero in address phase");
    a_data_pass: assert property (state_reg == XBM_DATA && write_reg |-> // [RQ4]
            exp_addr_data_out == wdata_reg && exp_addr_data_oe)
        else $error("write data altered on the bus");
    a_lane_data: assert property (state_reg == XBM_DATA |-> lane_select_n == be_n_reg) // [RQ6]
        else $error("lane selects differ from byte enables");
    a_lane_idle: assert property (state_reg != XBM_DATA |-> lane_select_n == `XBM_LANES_IDLE) // [RQ7]
        else $error("lane select active outside data phase");
    a_write_rise: assert property ($rose(write_strobe_n) && style_reg == XBM_LATCH_STYLE |-> // [RQ8]
            state_reg == XBM_FINISH && write_reg)
        else $error("write strobe rose outside end of write");
    a_dir_hold: assert property (style_reg == XBM_STROBE_STYLE &&        // [RQ9]
            state_reg inside {XBM_ADDR, XBM_DATA} |-> write_strobe_n == !write_reg)
        else $error("direction signal wrong during access");
    a_read_high: assert property (style_reg == XBM_LATCH_STYLE && write_reg |-> data_strobe_n) // [RQ10]
        else $error("read strobe low during write");
    a_ds_hold: assert property (style_reg == XBM_STROBE_STYLE && $fell(data_strobe_n) |-> // [RQ11]
            !data_strobe_n throughout (state_reg == XBM_DATA)[*2])
        else $error("data strobe released early");
    a_as_hold: assert property ($fell(addr_strobe_n) |->                 // [RQ12] [RQ13]
            !addr_strobe_n until_with (state_reg == XBM_DATA && state_next == XBM_FINISH))
        else $error("address strobe released before data phase end");
    a_as_bound: assert property ($fell(addr_strobe_n) |-> ##[1:60] addr_strobe_n) // [RQ13]
        else $error("address strobe held too long");
    a_irq_relay: assert property ($fell(irq_s_n) |=> !pci_intb_n)      // [RQ14]
        else $error("local interrupt not relayed");
    a_req_need: assert property (state_reg == XBM_REQ |-> !request_alt_n && grant_ack_n) // [RQ15] [RQ17]
        else $error("bus request missing while waiting");
    a_no_drive: assert property (!exp_ctrl_oe && !$past(exp_ctrl_oe) |-> !exp_addr_data_oe) // [RQ18]
        else $error("bus driven without ownership");
    a_ack_grant: assert property ($fell(grant_ack_n) |-> $past(granted)) // [RQ17] [RQ18]
        else $error("acknowledge without grant");
    a_miss_decode: assert property (take && !hit |=> rsp_valid && rsp_miss && state_reg == XBM_IDLE) // [RQ19]
        else $error("unmatched address started a bus cycle");

    c_write: cover property (state_reg == XBM_FINISH && write_reg);
    c_read: cover property (state_reg == XBM_FINISH && !write_reg);
    c_strobe_style: cover property (style_reg == XBM_STROBE_STYLE && state_reg == XBM_DATA);
    c_miss: cover property (rsp_valid && rsp_miss);

endmodule

// ### tb/xbm_peer.sv
`timescale 1ns/1ps
module xbm_peer (
    // clock, reset and setup
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        strobe_style,
    input  wire logic [7:0]  gnt_dly,
    // port side of the bus
    input  wire logic        request_alt_n,
    input  wire logic        grant_ack_n,
    input  wire logic [31:0] exp_addr_data_out,
    input  wire logic        exp_addr_data_oe,
    input  wire logic        exp_ctrl_oe,
    input  wire logic [3:0]  lane_select_n,
    input  wire logic        write_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        addr_strobe_n,
    // far side back to the port
    output logic [31:0]      exp_addr_data_in,
    output logic             bus_grant_in,
    output logic             grant_alt_n,
    // what the peripherals saw
    output logic [31:0]      mem_reg,
    output logic [31:0]      addr_reg,
    output logic [3:0]       lanes_reg,
    output logic [15:0]      bad_reg
);
    logic [7:0]  cnt_reg;
    logic        gnt_reg;
    logic [31:0] last_reg;
    logic [31:0] dout_reg;
    logic [3:0]  plane_reg;
    logic        pws_reg;
    logic        pds_reg;
    logic        pas_reg;
    logic [3:0]  lanes;
    logic        ws;
    logic        ds;
    logic        as_e;
    logic        rd_on;
    logic        wr_evt;
    logic        viol;

    // released control lines float high
    assign lanes  = exp_ctrl_oe ? lane_select_n : 4'hf;
    assign ws     = exp_ctrl_oe ? write_strobe_n : 1'b1;
    assign ds     = exp_ctrl_oe ? data_strobe_n : 1'b1;
    assign as_e   = exp_ctrl_oe ? addr_strobe_n : 1'b1;
    assign rd_on  = !ds && (strobe_style ? ws : 1'b1);
    assign wr_evt = strobe_style ? (!pds_reg && ds && !pws_reg) : (!pws_reg && ws);
    // grant on the pin of the chosen style
    assign bus_grant_in = strobe_style ? 1'b0 : gnt_reg;
    assign grant_alt_n  = strobe_style ? !gnt_reg : 1'b1;

    // selected bytes drive on read; undriven lines wander
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (exp_addr_data_oe)
                exp_addr_data_in[8*i+:8] = exp_addr_data_out[8*i+:8];
            else if (rd_on && !lanes[i])
                exp_addr_data_in[8*i+:8] = mem_reg[8*i+:8];
            else
                exp_addr_data_in[8*i+:8] = ~last_reg[8*i+:8];
        end
    end

    // protocol faults seen on the bus
    assign viol = ((exp_addr_data_oe || exp_ctrl_oe) && !gnt_reg)
               || (grant_ack_n ? lanes != 4'hf : !exp_ctrl_oe)
               || (lanes != 4'hf && as_e)
               || (pas_reg && !as_e && lanes != 4'hf)
               || (!strobe_style && !ws && !ds)
               || (strobe_style && !pas_reg && !as_e && ws != pws_reg)
               || (lanes != 4'hf && (strobe_style ? ds : (ws && ds)));

    // arbiter: tied when alone, else grants after gnt_dly cycles
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= 8'h00;
            gnt_reg <= 1'b0;
        end else if (gnt_dly == 8'h00 || (!request_alt_n && cnt_reg == gnt_dly)) begin
            gnt_reg <= 1'b1;
        end else if (request_alt_n) begin
            cnt_reg <= 8'h00;
            gnt_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // latch address; write bytes taken on the closing edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_reg   <= 32'h0000_0000;
            addr_reg  <= 32'h0000_0000;
            lanes_reg <= 4'hf;
            bad_reg   <= 16'h0000;
            last_reg  <= 32'h0000_0000;
            dout_reg  <= 32'h0000_0000;
            plane_reg <= 4'hf;
            pws_reg   <= 1'b1;
            pds_reg   <= 1'b1;
            pas_reg   <= 1'b1;
        end else begin
            last_reg  <= exp_addr_data_in;
            dout_reg  <= exp_addr_data_out;
            plane_reg <= lanes;
            pws_reg   <= ws;
            pds_reg   <= ds;
            pas_reg   <= as_e;
            bad_reg   <= bad_reg + {15'h0000, viol};
            if (pas_reg && !as_e)
                addr_reg <= exp_addr_data_out;
            if (lanes != 4'hf)
                lanes_reg <= lanes;
            for (int i = 0; i < 4; i++) begin
                if (wr_evt && !plane_reg[i])
                    mem_reg[8*i+:8] <= dout_reg[8*i+:8];
            end
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import xbm_pkg::*;
;
    localparam int LIMIT = 20000;
    logic        ref_clk, sys_rst, strobe_style, req_valid, req_ready, req_write, rsp_valid, rsp_miss;
    logic        pci_clk_in, pci_intb_n, exp_clock_out, exp_addr_data_oe, write_strobe_n, data_strobe_n;
    logic        addr_strobe_n, exp_ctrl_oe, local_irq_in_n, request_alt_n, bus_grant_in, grant_alt_n;
    logic        grant_ack_n, hit;
    logic [11:0] expansion_space;
    logic [3:0]  req_be_n, lane_select_n, seen_lanes, ch_reg, ih_reg;
    logic [31:0] req_addr, req_wdata, rsp_rdata, exp_addr_data_in, exp_addr_data_out, seen_mem, seen_addr;
    logic [31:0] ref_mem, rnd, addr;
    logic [15:0] bad_cnt;
    logic [7:0]  gnt_dly;
    int          failures, samples_checked, cycles, seed;

    xbm_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .strobe_style(strobe_style),
        .expansion_space(expansion_space), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_write(req_write), .req_be_n(req_be_n), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_miss(rsp_miss), .rsp_rdata(rsp_rdata), .pci_clk_in(pci_clk_in), .pci_intb_n(pci_intb_n),
        .exp_clock_out(exp_clock_out), .exp_addr_data_in(exp_addr_data_in), .exp_addr_data_out(exp_addr_data_out),
        .exp_addr_data_oe(exp_addr_data_oe), .lane_select_n(lane_select_n), .write_strobe_n(write_strobe_n),
        .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n), .exp_ctrl_oe(exp_ctrl_oe),
        .local_irq_in_n(local_irq_in_n), .request_alt_n(request_alt_n), .bus_grant_in(bus_grant_in),
        .grant_alt_n(grant_alt_n), .grant_ack_n(grant_ack_n));

    xbm_peer peer (.ref_clk(ref_clk), .sys_rst(sys_rst), .strobe_style(strobe_style), .gnt_dly(gnt_dly),
        .request_alt_n(request_alt_n), .grant_ack_n(grant_ack_n), .exp_addr_data_out(exp_addr_data_out),
        .exp_addr_data_oe(exp_addr_data_oe), .exp_ctrl_oe(exp_ctrl_oe), .lane_select_n(lane_select_n),
        .write_strobe_n(write_strobe_n), .data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n),
        .exp_addr_data_in(exp_addr_data_in), .bus_grant_in(bus_grant_in), .grant_alt_n(grant_alt_n),
        .mem_reg(seen_mem), .addr_reg(seen_addr), .lanes_reg(seen_lanes), .bad_reg(bad_cnt));

    // pci clock edges fall on core falling edges, never on rising ones
    always #12.5 ref_clk = ~ref_clk;
    always #100 pci_clk_in = ~pci_clk_in;

    // pin history and watchdog
    always @(posedge ref_clk) begin
        ch_reg <= {ch_reg[2:0], pci_clk_in};
        ih_reg <= {ih_reg[2:0], local_irq_in_n};
        cycles++;
        if (cycles > LIMIT) begin
            $display("mismatch at %0t: run did not finish", $time);
            failures++;
            tally_and_finish;
        end
    end

    // relays against the pin history, once reset and history have settled
    always @(negedge ref_clk) begin
        if (cycles > 24) begin
            cmp1(exp_clock_out, ~ch_reg[2], "bus clock");
            cmp1(pci_intb_n, ih_reg[2], "interrupt relay");
        end
    end

    task automatic cmp1(input logic got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // request held until taken; answer checked against the model
    task automatic access(input logic wr, sty, hit_e, input logic [3:0] be, input logic [31:0] a, d);
        int          n;
        logic [31:0] mask;
        n = 0;
        for (int i = 0; i < 4; i++)
            mask[8*i+:8] = be[i] ? 8'h00 : 8'hff;
        @(posedge ref_clk);
        #2;
        strobe_style = sty;
        req_valid = 1'b1;
        req_addr = a;
        req_write = wr;
        req_be_n = be;
        req_wdata = d;
        @(posedge ref_clk);
        while (req_ready !== 1'b1 && n < 100) begin
            n++;
            @(posedge ref_clk);
        end
        #2;
        req_valid = 1'b0;
        req_wdata = ~d;
        n = 0;
        if (hit_e) begin
            repeat (2) @(posedge ref_clk);
            #2;
            cmp1(request_alt_n, 1'b0, "bus request");
        end else
            cmp1(request_alt_n, 1'b1, "request on miss");
        // a miss answers in the cycle right after the take
        while (rsp_valid !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #2;
            n++;
        end
        cmp1(rsp_valid, 1'b1, "answer");
        cmp1(rsp_miss, !hit_e, "miss flag");
        if (hit_e) begin
            cmp32(seen_addr, {14'h0000, a[19:2]}, "address phase");
            if (be != 4'hf)
                cmp32({28'h000_0000, seen_lanes}, {28'h000_0000, be}, "lane selects");
            if (wr) begin
                ref_mem = (ref_mem & ~mask) | (d & mask);
                cmp32(seen_mem, ref_mem, "written bytes");
            end else begin
                cmp32(rsp_rdata & mask, ref_mem & mask, "read bytes");
            end
        end
    endtask

    task automatic tally_and_finish;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {ref_clk, pci_clk_in, strobe_style, req_valid, req_write} = 5'h00;
        {sys_rst, local_irq_in_n} = 2'h3;
        expansion_space = 12'h5a3;
        req_be_n = 4'hf;
        {req_addr, req_wdata, ref_mem} = '0;
        gnt_dly = 8'h00;
        {failures, samples_checked, cycles} = 0;
        seed = 57832;
        repeat (16) @(posedge ref_clk);
        #2;
        sys_rst = 1'b0;
        // both styles, write then read, tied and handshaken grant
        for (int k = 0; k < 4; k++) begin
            gnt_dly = k[1] ? 8'h05 : 8'h00;
            access(!k[0], k[1] ? XBM_STROBE_STYLE : XBM_LATCH_STYLE, 1'b1, 4'h0,
                   {expansion_space, 20'hf_fffc}, 32'ha5c3_0f96 ^ k);
        end
        // random styles, lanes, misses, grants and interrupts
        for (int k = 0; k < 60; k++) begin
            rnd = $random(seed);
            gnt_dly = rnd[2] ? 8'h00 : {4'h0, rnd[7:4]};
            local_irq_in_n = rnd[3];
            if (rnd[9:8] == 2'h0)
                expansion_space = rnd[31:20];
            hit = rnd[10] | rnd[11];
            addr = $random(seed);
            addr[31:20] = hit ? expansion_space : expansion_space ^ (rnd[27:16] | 12'h001);
            access(rnd[12], rnd[13], hit, rnd[17:14], addr, $random(seed));
        end
        cmp32({16'h0000, bad_cnt}, 32'h0000_0000, "bus protocol faults");
        tally_and_finish;
    end
endmodule
